// [design/timer_compare_pkg.sv]
package timer_compare_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'h12;
   localparam logic [7:0] IDX_FLAGS = 8'h13;
   localparam logic [7:0] IDX_CAPTURE_HIGH = 8'h14;
   localparam logic [7:0] IDX_CAPTURE_LOW = 8'h15;
   localparam logic [7:0] IDX_COMPARE_HIGH = 8'h16;
   localparam logic [7:0] IDX_COMPARE_LOW = 8'h17;
   localparam logic [7:0] IDX_COUNTER_HIGH = 8'h18;
   localparam logic [7:0] IDX_COUNTER_LOW = 8'h19;

   localparam int CTRL_CAPTURE_IE_BIT = 7;
   localparam int CTRL_COMPARE_IE_BIT = 6;
   localparam int CTRL_OVERFLOW_IE_BIT = 5;
   localparam int CTRL_EDGE_SEL_BIT = 1;
   localparam int CTRL_OUT_LEVEL_BIT = 0;
   localparam int FLAG_CAPTURE_BIT = 7;
   localparam int FLAG_COMPARE_BIT = 6;
   localparam int FLAG_OVERFLOW_BIT = 5;

   localparam logic [15:0] COUNTER_RESET = 16'hFFFC;
   localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic aw_ready;
      logic w_ready;
      logic ar_ready;
      logic aw_held;
      logic [7:0] aw_idx;
      logic w_held;
      logic [7:0] w_byte;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [1:0] prescale;
      logic [15:0] counter;
      logic [7:0] counter_low_hold;
      logic counter_low_held;
      logic [15:0] compare_value;
      logic compare_inhibit;
      logic capture_ie;
      logic compare_ie;
      logic overflow_ie;
      logic edge_sel;
      logic out_level;
      logic capture_flag;
      logic compare_flag;
      logic overflow_flag;
      logic capture_armed;
      logic compare_armed;
      logic overflow_armed;
      logic [15:0] capture_value;
      logic capture_block;
      logic source_prev;
      logic stop_pending;
      logic [15:0] stop_value;
      logic stop_prev;
      logic pin;
      logic irq;
   } timer_state_t;
endpackage

// [design/timer_compare_control_status.sv]
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module timer_compare_control_status (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_on_reset_n,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic capture_input_pin,
   input wire logic comparator_event_flag,
   input wire logic capture_source_sel,
   input wire logic stop_mode,
   output logic compare_output_pin,
   output logic timer_irq
);
   timer_compare_pkg::timer_state_t state_ff;
   timer_compare_pkg::timer_state_t nxt_state;

   function automatic logic mapped(input logic [7:0] idx);
      mapped = idx >= timer_compare_pkg::IDX_CONTROL && idx <= timer_compare_pkg::IDX_COUNTER_LOW;
   endfunction

   logic ar_take;
   logic wr_do;
   logic [7:0] ar_idx;
   logic source;
   logic edge_seen;
   logic tick;
   logic [15:0] counter_next;
   logic [7:0] rd_byte;

   assign s_axi_awready = state_ff.aw_ready;
   assign s_axi_wready = state_ff.w_ready;
   assign s_axi_bvalid = state_ff.bvalid;
   assign s_axi_bresp = state_ff.bresp;
   assign s_axi_arready = state_ff.ar_ready;
   assign s_axi_rvalid = state_ff.rvalid;
   assign s_axi_rresp = state_ff.rresp;
   assign s_axi_rdata = {24'h000000, state_ff.rdata};
   assign compare_output_pin = state_ff.pin;
   assign timer_irq = state_ff.irq;

   always_comb begin
      nxt_state = state_ff;
      ar_idx = s_axi_araddr[9:2];
      ar_take = s_axi_arvalid && !state_ff.rvalid;
      wr_do = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;
      source = capture_source_sel ? comparator_event_flag : capture_input_pin;
      edge_seen = state_ff.edge_sel ? (source && !state_ff.source_prev) : (!source && state_ff.source_prev);
      // fixed divide-by-four; stop freezes prescaler and counter
      tick = !stop_mode && state_ff.prescale == timer_compare_pkg::PRESCALE_LAST;
      counter_next = state_ff.counter + 16'h0001;
      rd_byte = 8'h00;

      // bus channels: address and data taken in either order
      if (s_axi_awvalid && !state_ff.aw_held) begin
         nxt_state.aw_held = 1'b1;
         nxt_state.aw_idx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !state_ff.w_held) begin
         nxt_state.w_held = 1'b1;
         nxt_state.w_byte = s_axi_wdata[7:0];
         nxt_state.w_lane0 = s_axi_wstrb[0];
      end
      if (state_ff.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end
      if (state_ff.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end

      // register reads and their side effects
      if (ar_take) begin
         unique case (ar_idx)
            timer_compare_pkg::IDX_CONTROL: begin
               rd_byte[timer_compare_pkg::CTRL_CAPTURE_IE_BIT] = state_ff.capture_ie;
               rd_byte[timer_compare_pkg::CTRL_COMPARE_IE_BIT] = state_ff.compare_ie;
               rd_byte[timer_compare_pkg::CTRL_OVERFLOW_IE_BIT] = state_ff.overflow_ie;
               rd_byte[timer_compare_pkg::CTRL_EDGE_SEL_BIT] = state_ff.edge_sel;
               rd_byte[timer_compare_pkg::CTRL_OUT_LEVEL_BIT] = state_ff.out_level;
            end
            timer_compare_pkg::IDX_FLAGS: begin
               // flags on top three bits, low bits zero
               rd_byte[timer_compare_pkg::FLAG_CAPTURE_BIT] = state_ff.capture_flag;
               rd_byte[timer_compare_pkg::FLAG_COMPARE_BIT] = state_ff.compare_flag;
               rd_byte[timer_compare_pkg::FLAG_OVERFLOW_BIT] = state_ff.overflow_flag;
               // arming only when the flag is seen set
               nxt_state.capture_armed = state_ff.capture_armed || state_ff.capture_flag;
               nxt_state.compare_armed = state_ff.compare_armed || state_ff.compare_flag;
               nxt_state.overflow_armed = state_ff.overflow_armed || state_ff.overflow_flag;
            end
            timer_compare_pkg::IDX_CAPTURE_HIGH: begin
               rd_byte = state_ff.capture_value[15:8];
               nxt_state.capture_block = 1'b1;
            end
            timer_compare_pkg::IDX_CAPTURE_LOW: begin
               rd_byte = state_ff.capture_value[7:0];
               nxt_state.capture_block = 1'b0;
               if (state_ff.capture_armed) begin
                  nxt_state.capture_flag = 1'b0;
                  nxt_state.capture_armed = 1'b0;
               end
            end
            timer_compare_pkg::IDX_COMPARE_HIGH: begin
               rd_byte = state_ff.compare_value[15:8];
            end
            timer_compare_pkg::IDX_COMPARE_LOW: begin
               rd_byte = state_ff.compare_value[7:0];
               // read of low compare byte clears when armed
               if (state_ff.compare_armed) begin
                  nxt_state.compare_flag = 1'b0;
                  nxt_state.compare_armed = 1'b0;
               end
            end
            timer_compare_pkg::IDX_COUNTER_HIGH: begin
               rd_byte = state_ff.counter[15:8];
               // low byte frozen so a two-byte read is coherent
               if (!state_ff.counter_low_held) begin
                  nxt_state.counter_low_hold = state_ff.counter[7:0];
                  nxt_state.counter_low_held = 1'b1;
               end
            end
            timer_compare_pkg::IDX_COUNTER_LOW: begin
               rd_byte = state_ff.counter_low_held ? state_ff.counter_low_hold : state_ff.counter[7:0];
               nxt_state.counter_low_held = 1'b0;
               if (state_ff.overflow_armed) begin
                  nxt_state.overflow_flag = 1'b0;
                  nxt_state.overflow_armed = 1'b0;
               end
            end
            default: begin
               rd_byte = 8'h00;
            end
         endcase
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata = rd_byte;
         nxt_state.rresp = mapped(ar_idx) ? timer_compare_pkg::RESP_OKAY : timer_compare_pkg::RESP_SLVERR;
      end

      // register writes; flag register ignores writes
      if (wr_do) begin
         nxt_state.aw_held = 1'b0;
         nxt_state.w_held = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp = mapped(state_ff.aw_idx) ? timer_compare_pkg::RESP_OKAY : timer_compare_pkg::RESP_SLVERR;
         unique case (state_ff.aw_idx)
            timer_compare_pkg::IDX_CONTROL: begin
               if (state_ff.w_lane0) begin
                  nxt_state.capture_ie = state_ff.w_byte[timer_compare_pkg::CTRL_CAPTURE_IE_BIT];
                  nxt_state.compare_ie = state_ff.w_byte[timer_compare_pkg::CTRL_COMPARE_IE_BIT];
                  nxt_state.overflow_ie = state_ff.w_byte[timer_compare_pkg::CTRL_OVERFLOW_IE_BIT];
                  nxt_state.edge_sel = state_ff.w_byte[timer_compare_pkg::CTRL_EDGE_SEL_BIT];
                  nxt_state.out_level = state_ff.w_byte[timer_compare_pkg::CTRL_OUT_LEVEL_BIT];
               end
            end
            timer_compare_pkg::IDX_COMPARE_HIGH: begin
               if (state_ff.w_lane0) begin
                  nxt_state.compare_value[15:8] = state_ff.w_byte;
                  nxt_state.compare_inhibit = 1'b1;
               end
            end
            timer_compare_pkg::IDX_COMPARE_LOW: begin
               if (state_ff.w_lane0) begin
                  nxt_state.compare_value[7:0] = state_ff.w_byte;
                  nxt_state.compare_inhibit = 1'b0;
               end
               // write access also clears when armed
               if (state_ff.compare_armed) begin
                  nxt_state.compare_flag = 1'b0;
                  nxt_state.compare_armed = 1'b0;
               end
            end
            timer_compare_pkg::IDX_COUNTER_LOW: begin
               // any access counts, counter itself is read-only
               if (state_ff.overflow_armed) begin
                  nxt_state.overflow_flag = 1'b0;
                  nxt_state.overflow_armed = 1'b0;
               end
            end
            default: begin
               nxt_state.bvalid = 1'b1;
            end
         endcase
      end

      // timebase; wait mode needs nothing special, timer keeps running
      if (!stop_mode) begin
         nxt_state.prescale = state_ff.prescale + 2'h1;
      end
      if (tick) begin
         nxt_state.counter = counter_next;
         // wrap sets flag, wins over a clear
         if (state_ff.counter == timer_compare_pkg::COUNTER_MAX) begin
            nxt_state.overflow_flag = 1'b1;
         end
         if (!state_ff.compare_inhibit && counter_next == state_ff.compare_value) begin
            // match sets flag, wins over a clear
            nxt_state.compare_flag = 1'b1;
            // level copied to pin; regardless of flag; level select
            nxt_state.pin = state_ff.out_level;
         end
      end

      // capture path
      nxt_state.source_prev = source;
      nxt_state.stop_prev = stop_mode;
      if (edge_seen) begin
         if (stop_mode) begin
            // only the first edge in stop arms
            if (!state_ff.stop_pending) begin
               nxt_state.stop_pending = 1'b1;
               nxt_state.stop_value = state_ff.counter;
            end
         end else if (!state_ff.capture_block) begin
            nxt_state.capture_value = state_ff.counter;
            nxt_state.capture_flag = 1'b1;
         end
      end
      // wake without reset resumes; armed edge delivered now
      if (state_ff.stop_prev && !stop_mode && state_ff.stop_pending) begin
         nxt_state.stop_pending = 1'b0;
         nxt_state.capture_value = state_ff.stop_value;
         nxt_state.capture_flag = 1'b1;
      end

      // level request from flag and enable; gate each source
      nxt_state.irq = (state_ff.capture_flag && state_ff.capture_ie) ||
         (state_ff.compare_flag && state_ff.compare_ie) ||
         (state_ff.overflow_flag && state_ff.overflow_ie);

      if (!power_on_reset_n) begin
         // power-up gives the kept fields a known start
         nxt_state = '0;
         nxt_state.counter = timer_compare_pkg::COUNTER_RESET;
      end else if (!aresetn) begin
         // compare value, flags and capture data survive
         nxt_state.aw_held = 1'b0;
         nxt_state.w_held = 1'b0;
         nxt_state.bvalid = 1'b0;
         nxt_state.rvalid = 1'b0;
         nxt_state.prescale = 2'h0;
         // counter preset even when leaving stop
         nxt_state.counter = timer_compare_pkg::COUNTER_RESET;
         nxt_state.counter_low_held = 1'b0;
         nxt_state.compare_inhibit = 1'b0;
         nxt_state.capture_ie = 1'b0;
         nxt_state.compare_ie = 1'b0;
         nxt_state.overflow_ie = 1'b0;
         nxt_state.out_level = 1'b0;
         nxt_state.edge_sel = state_ff.edge_sel;
         nxt_state.capture_flag = state_ff.capture_flag;
         nxt_state.compare_flag = state_ff.compare_flag;
         nxt_state.overflow_flag = state_ff.overflow_flag;
         nxt_state.capture_armed = 1'b0;
         nxt_state.compare_armed = 1'b0;
         nxt_state.overflow_armed = 1'b0;
         nxt_state.capture_block = 1'b0;
         // edge armed in stop is dropped on reset
         nxt_state.stop_pending = 1'b0;
         nxt_state.stop_prev = 1'b0;
         nxt_state.pin = 1'b0;
         nxt_state.irq = 1'b0;
      end
      // readys kept in flops so no bus output passes through a gate
      nxt_state.aw_ready = !nxt_state.aw_held;
      nxt_state.w_ready = !nxt_state.w_held;
      nxt_state.ar_ready = !nxt_state.rvalid;
   end

   always_ff @(posedge aclk) begin
      state_ff <= nxt_state;
   end
endmodule

// [verification/timer_compare_control_status_properties.sv]
`timescale 1ns/1ps
module timer_compare_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_on_reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic stop_mode,
   input wire logic compare_output_pin,
   input wire logic timer_irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !power_on_reset_n);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_pin_moves;
      !$stable(compare_output_pin);
   endsequence
   property p_wr_answer;
      s_wr_taken |=> ##1 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response not in time");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read data not in time");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_rdata_byte;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_rdata_byte: assert property (p_rdata_byte) else $error("read upper bits not zero");
   // separate disable: this one looks at the device reset itself
   property p_reset_out;
      disable iff (!power_on_reset_n) !aresetn |=> !compare_output_pin && !timer_irq;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
   property p_stop_freeze;
      stop_mode |=> $stable(compare_output_pin);
   endproperty
   a_stop_freeze: assert property (p_stop_freeze) else $error("pin moved in stop");
   // compares only on a prescaler tick, so pin moves at most once per four clocks
   property p_tick_gap;
      s_pin_moves |=> $stable(compare_output_pin) [*3];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("pin moved between ticks");
endmodule
bind timer_compare_control_status timer_compare_checker u_chk (.aclk, .aresetn, .power_on_reset_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .stop_mode,
   .compare_output_pin, .timer_irq);

// [verification/timer_compare_control_status_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module timer_compare_control_status_tb;
   logic aclk, aresetn, por_n, aw_v, w_v, b_rdy, ar_v, r_rdy, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
   logic cap_pin, stop, pin, irq, cmp_ev, src_sel;
   logic [31:0] aw_a, w_d, ar_a, r_d;
   logic [1:0] b_r, r_r, resp, bres;
   logic [7:0] v;
   logic [15:0] t, s, u;
   int error_cnt, checks, cyc;
   timer_compare_control_status dut (.aclk(aclk), .aresetn(aresetn), .power_on_reset_n(por_n),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_r),
      .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_r), .s_axi_rvalid(r_v),
      .s_axi_rready(r_rdy), .capture_input_pin(cap_pin), .comparator_event_flag(cmp_ev),
      .capture_source_sel(src_sel), .stop_mode(stop), .compare_output_pin(pin), .timer_irq(irq));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 10000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge aclk);
      aw_a <= {22'h0, idx, 2'h0};
      w_d <= {24'h0, d};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_rdy <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw_rdy === 1'b1) aw_v <= 1'b0;
         if (w_rdy === 1'b1) w_v <= 1'b0;
      end while (b_v !== 1'b1);
      b_rdy <= 1'b0;
      bres = b_r;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      @(posedge aclk);
      ar_a <= {22'h0, idx, 2'h0};
      ar_v <= 1'b1;
      r_rdy <= 1'b1;
      do begin
         @(posedge aclk);
         if (ar_rdy === 1'b1) ar_v <= 1'b0;
      end while (r_v !== 1'b1);
      r_rdy <= 1'b0;
      d = r_d[7:0];
      resp = r_r;
   endtask
   task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e, input string n);
      rd(idx, v);
      `CHK(n, e, v)
   endtask
   // high first: its read latches the low byte
   task automatic rd_cnt(output logic [15:0] c);
      rd(timer_compare_pkg::IDX_COUNTER_HIGH, c[15:8]);
      rd(timer_compare_pkg::IDX_COUNTER_LOW, c[7:0]);
   endtask
   task automatic wait_pin(input logic e);
      int n;
      n = 0;
      while (pin !== e && n < 1000) begin
         @(posedge aclk);
         n++;
      end
      `CHK("compare pin", e, pin)
   endtask
   initial begin
      {aresetn, por_n, aw_v, w_v, b_rdy, ar_v, r_rdy, cap_pin, stop, cmp_ev, src_sel} = '0;
      {aw_a, w_d, ar_a} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      por_n <= 1'b1;
      chk_rd(timer_compare_pkg::IDX_CONTROL, 8'h00, "control");
      chk_rd(8'h40, 8'h00, "unmapped");
      `CHK("unmapped resp", timer_compare_pkg::RESP_SLVERR, resp)
      wr(8'h40, 8'h00);
      `CHK("unmapped wr resp", timer_compare_pkg::RESP_SLVERR, bres)
      repeat (40) @(posedge aclk);
      // power-up compare value is zero, so the wrap also matches
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h60, "wrap");
      wr(timer_compare_pkg::IDX_FLAGS, 8'hFF);
      `CHK("flags wr resp", timer_compare_pkg::RESP_OKAY, bres)
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h60, "flags write");
      wr(timer_compare_pkg::IDX_CONTROL, 8'hE3);
      chk_rd(timer_compare_pkg::IDX_CONTROL, 8'hE3, "control rw");
      `CHK("irq on", 1'b1, irq)
      wr(timer_compare_pkg::IDX_CONTROL, 8'h83);
      repeat (2) @(posedge aclk);
      `CHK("irq off", 1'b0, irq)
      rd_cnt(t);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h40, "overflow clear");
      t = t + 16'h0040;
      wr(timer_compare_pkg::IDX_COMPARE_HIGH, t[15:8]);
      wr(timer_compare_pkg::IDX_COMPARE_LOW, t[7:0]);
      repeat (96) @(posedge aclk);
      `CHK("pin early", 1'b0, pin)
      wait_pin(1'b1);
      t = t + 16'h0020;
      wr(timer_compare_pkg::IDX_CONTROL, 8'h00);
      wr(timer_compare_pkg::IDX_COMPARE_HIGH, t[15:8]);
      wr(timer_compare_pkg::IDX_COMPARE_LOW, t[7:0]);
      wait_pin(1'b0);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h40, "flag still set");
      chk_rd(timer_compare_pkg::IDX_COMPARE_HIGH, t[15:8], "compare rw");
      rd(timer_compare_pkg::IDX_COMPARE_LOW, v);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h00, "compare clear");
      // low first, so the high write leaves the compare inhibited
      wr(timer_compare_pkg::IDX_CONTROL, 8'h01);
      rd_cnt(t);
      t = t + 16'h0020;
      wr(timer_compare_pkg::IDX_COMPARE_LOW, t[7:0]);
      wr(timer_compare_pkg::IDX_COMPARE_HIGH, t[15:8]);
      repeat (192) @(posedge aclk);
      `CHK("inhibited", 1'b0, pin)
      rd_cnt(t);
      t = t + 16'h0020;
      wr(timer_compare_pkg::IDX_COMPARE_HIGH, t[15:8]);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h00, "no inhibited match");
      wr(timer_compare_pkg::IDX_COMPARE_LOW, t[7:0]);
      wait_pin(1'b1);
      wr(timer_compare_pkg::IDX_CONTROL, 8'h42);
      repeat (2) @(posedge aclk);
      `CHK("compare irq", 1'b1, irq)
      wr(timer_compare_pkg::IDX_CONTROL, 8'h82);
      cap_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK("capture irq", 1'b1, irq)
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'hC0, "capture set");
      rd(timer_compare_pkg::IDX_CAPTURE_LOW, v);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h40, "capture clear");
      cap_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h40, "falling ignored");
      rd(timer_compare_pkg::IDX_CAPTURE_HIGH, v);
      cap_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h40, "capture blocked");
      rd(timer_compare_pkg::IDX_CAPTURE_LOW, v);
      // switching source gives a falling edge, which is ignored here
      src_sel <= 1'b1;
      repeat (2) @(posedge aclk);
      cmp_ev <= 1'b1;
      repeat (4) @(posedge aclk);
      `CHK("comparator irq", 1'b1, irq)
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'hC0, "comparator capture");
      rd(timer_compare_pkg::IDX_CAPTURE_LOW, v);
      cap_pin <= 1'b0;
      src_sel <= 1'b0;
      stop <= 1'b1;
      rd_cnt(s);
      repeat (20) @(posedge aclk);
      cap_pin <= 1'b1;
      rd_cnt(u);
      `CHK("frozen", s, u)
      stop <= 1'b0;
      repeat (2) @(posedge aclk);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'hC0, "wake capture");
      chk_rd(timer_compare_pkg::IDX_CAPTURE_HIGH, s[15:8], "wake value high");
      chk_rd(timer_compare_pkg::IDX_CAPTURE_LOW, s[7:0], "wake value low");
      rd_cnt(u);
      `CHK("resumed", 1'b1, u > s && u - s < 16'h0010)
      cap_pin <= 1'b0;
      stop <= 1'b1;
      repeat (4) @(posedge aclk);
      cap_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_cnt(u);
      `CHK("preset", timer_compare_pkg::COUNTER_RESET, u)
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h40, "flags kept");
      chk_rd(timer_compare_pkg::IDX_CONTROL, 8'h02, "edge kept");
      chk_rd(timer_compare_pkg::IDX_COMPARE_LOW, t[7:0], "compare kept");
      stop <= 1'b0;
      repeat (2) @(posedge aclk);
      chk_rd(timer_compare_pkg::IDX_FLAGS, 8'h00, "no capture after reset");
      report_and_stop();
   end
endmodule
